// file: logic/lal_pkg.sv
// Functional notes
// - during loss with receive substitution on, system receive data is all ones.
// - during loss with substitution off, received pulses and recovered clock pass through.
// - while receive substitution runs, receive clock output follows the master clock.
// - transmit alarm-on-loss set sends all ones on line, timed by master clock.
// - loss detection and reporting continue in every loopback mode.
// - declare loss after 175/1544 (T1) or 32/2048 (E1) consecutive low intervals.
// - T1 clear after 128 good intervals, 12.5% marks, under 100 consecutive zeros.
// - E1 clear after 32 good intervals, 12.5% marks, under 16 consecutive zeros.
// - long haul code maps to -4 dB minus 2 dB per step, floor -48 dB.
// - alarm indication detection runs only with clock recovery on; state is readable.
// - in E1 the criterion bit picks the alarm rule; T1 has one rule.
// - E1 select 0 declares alarm after two 512-bit blocks each under 3 zeros.
// - E1 select 0 clears alarm after two 512-bit blocks each with 3+ zeros.
// - E1 select 1 clears alarm after one 512-bit block with 3+ zeros.
// - T1 declares alarm when an 8192-bit block holds fewer than 9 zeros.
// - T1 clears alarm when an 8192-bit block holds 9 or more zeros.
// - transmit patterns use the transmit clock, or master clock when selected.
// - pattern clock 0 with pattern 00 sends normal system data.
// - pattern 01 sends all ones on the selected pattern clock.
// - pattern clock 1 with pattern 00 sends all zeros.
// - loss pin is high while loss is declared, low once cleared.
// - pattern 10 sends the pseudo-random bit stream, most significant bit first.
// - pattern 11 repeatedly sends the loopback code stream.
// - loss declare counts come from criterion and line rate bits; clear counts come from the line rate bit alone.
package lal_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int T1_HZ = 1_544_000;
   localparam int E1_HZ = 2_048_000;
   // master clock bit periods as core_clk counts, rounded down
   localparam logic [5:0] MCLK_DIV_T1 = 6'(CLK_HZ / T1_HZ);
   localparam logic [5:0] MCLK_DIV_E1 = 6'(CLK_HZ / E1_HZ);

   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_THRESH = 4'h1;
   localparam logic [3:0] REG_STATUS = 4'h2;

   typedef struct packed {
      logic [2:0] loopbackMode;
      logic clockDataRecovery;
      logic [1:0] txPatternSelect;
      logic patternClkSelect;
      logic txAlarmOnLossEn;
      logic rxAlarmSubstituteEn;
      logic criterionSelect;
      logic lineRateSelect;
   } lal_ctrl_t;
   localparam logic [10:0] CTRL_RESET = 11'h080;
   localparam logic [4:0] THRESH_RESET = 5'h15;

   typedef struct packed {
      logic alarmIndStatus;
      logic lossOfSignal;
   } lal_status_t;

   localparam logic [1:0] PATT_NORMAL = 2'h0;
   localparam logic [1:0] PATT_ONES = 2'h1;
   localparam logic [1:0] PATT_PRBS = 2'h2;
   localparam logic [1:0] PATT_LOOP = 2'h3;

   localparam logic [11:0] LOS_N_T1_0 = 12'h0AF;
   localparam logic [11:0] LOS_N_T1_1 = 12'h608;
   localparam logic [11:0] LOS_N_E1_0 = 12'h020;
   localparam logic [11:0] LOS_N_E1_1 = 12'h800;
   localparam logic [7:0] LOS_M_T1 = 8'h80;
   localparam logic [7:0] LOS_M_E1 = 8'h20;
   localparam logic [6:0] LOS_ZMAX_T1 = 7'h64;
   localparam logic [6:0] LOS_ZMAX_E1 = 7'h10;

   localparam logic [13:0] AIS_BLK_E1 = 14'h0200;
   localparam logic [13:0] AIS_BLK_T1 = 14'h2000;
   localparam logic [3:0] AIS_ZTHR_E1 = 4'h3;
   localparam logic [3:0] AIS_ZTHR_T1 = 4'h9;

   localparam logic [4:0] THR_LAST_CODE = 5'h15;
   localparam logic signed [7:0] THR_TOP_DB = 8'shFC;
   localparam logic signed [7:0] THR_FLOOR_DB = 8'shD0;
   localparam logic signed [7:0] THR_HYST_DB = 8'sh04;
   localparam logic [1:0] RX_MARK = 2'h1;
   localparam logic [1:0] TX_MARK_POS = 2'h1;
   localparam logic [1:0] TX_MARK_NEG = 2'h2;
endpackage

// file: logic/lal_alarm.sv
// The placing of the registers and strobed register access were decided locally.
module lal_alarm
   import lal_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // register port
   input wire logic [3:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [15:0] regRdData,
   // receive line, one bit period per rxBitEn
   input wire logic rxBitEn,
   input wire logic rxDataPos,
   input wire logic rxDataNeg,
   input wire logic rxLevelLow,
   input wire logic rxLevelHigh,
   // system receive side
   output logic [1:0] rxDataPosNeg,
   output logic rxClkOut,
   // transmit side
   input wire logic txClkIn,
   input wire logic txSysData,
   input wire logic prbsBit,
   input wire logic loopCodeBit,
   output logic patternAdvance,
   output logic [1:0] txLinePair,
   output logic txClkOut,
   // status and slicer thresholds
   output logic lossSignalPin,
   output logic signed [7:0] lossDeclareDb,
   output logic signed [7:0] lossClearDb
);

   lal_ctrl_t ctrl_q;
   logic [4:0] thrCode_q;
   lal_status_t status_q;
   logic losQ;
   logic aisQ;

   // register port
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q <= lal_ctrl_t'(CTRL_RESET);
         thrCode_q <= THRESH_RESET;
      end else if (regWrEn) begin
         if (regAddr == REG_CTRL) begin
            ctrl_q <= lal_ctrl_t'(regWrData[10:0]);
         end
         if (regAddr == REG_THRESH) begin
            thrCode_q <= regWrData[4:0];
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         regRdData <= 16'h0000;
      end else if (regRdEn) begin
         unique case (regAddr)
            REG_CTRL: regRdData <= {5'h00, ctrl_q};
            REG_THRESH: regRdData <= {11'h000, thrCode_q};
            REG_STATUS: regRdData <= {14'h0000, status_q};
            default: regRdData <= 16'h0000;
         endcase
      end else begin
         regRdData <= 16'h0000;
      end
   end

   // status held in flops ahead of bits and pin, so reads never see a half-updated pair
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         status_q <= '0;
         lossSignalPin <= 1'b0;
      end else begin
         status_q <= '{alarmIndStatus: aisQ, lossOfSignal: losQ};
         lossSignalPin <= losQ;
      end
   end

   // long haul level thresholds for the slicer
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         lossDeclareDb <= THR_FLOOR_DB;
         lossClearDb <= THR_FLOOR_DB;
      end else if (thrCode_q > THR_LAST_CODE) begin
         lossDeclareDb <= THR_FLOOR_DB;
         lossClearDb <= THR_FLOOR_DB + THR_HYST_DB;
      end else begin
         lossDeclareDb <= THR_TOP_DB - 8'(signed'({2'h0, thrCode_q, 1'b0}));
         lossClearDb <= THR_TOP_DB - 8'(signed'({2'h0, thrCode_q, 1'b0})) + THR_HYST_DB;
      end
   end

   // master clock enable; rate follows the line rate select
   logic [5:0] mclkCnt_q;
   logic mclkEn_q;
   logic [5:0] mclkDiv;
   assign mclkDiv = ctrl_q.lineRateSelect ? MCLK_DIV_T1 : MCLK_DIV_E1;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         mclkCnt_q <= 6'h00;
         mclkEn_q <= 1'b0;
      end else if (mclkCnt_q >= mclkDiv - 6'h01) begin
         mclkCnt_q <= 6'h00;
         mclkEn_q <= 1'b1;
      end else begin
         mclkCnt_q <= mclkCnt_q + 6'h01;
         mclkEn_q <= 1'b0;
      end
   end

   // loss of signal counts
   logic [11:0] loss_signal_pin;
   logic [7:0] losM;
   logic [6:0] losZmax;
   always_comb begin
      unique case ({ctrl_q.lineRateSelect, ctrl_q.criterionSelect})
         2'b10: loss_signal_pin = LOS_N_T1_0;
         2'b11: loss_signal_pin = LOS_N_T1_1;
         2'b00: loss_signal_pin = LOS_N_E1_0;
         2'b01: loss_signal_pin = LOS_N_E1_1;
      endcase
      losM = ctrl_q.lineRateSelect ? LOS_M_T1 : LOS_M_E1;
      losZmax = ctrl_q.lineRateSelect ? LOS_ZMAX_T1 : LOS_ZMAX_E1;
   end

   logic rxMark;
   assign rxMark = rxDataPos | rxDataNeg;

   logic [11:0] lowCnt_q;
   logic winOn_q;
   logic [7:0] winCnt_q;
   logic [7:0] onesCnt_q;
   logic [6:0] zeroRun_q;
   logic [7:0] onesNext;
   assign onesNext = onesCnt_q + {7'h00, rxMark};

   // loopback mode is not looked at here, so no loopback can hide a loss
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         losQ <= 1'b0;
         lowCnt_q <= 12'h000;
         winOn_q <= 1'b0;
         winCnt_q <= 8'h00;
         onesCnt_q <= 8'h00;
         zeroRun_q <= 7'h00;
      end else if (rxBitEn) begin
         if (!losQ) begin
            winOn_q <= 1'b0;
            if (!rxLevelLow) begin
               lowCnt_q <= 12'h000;
            end else if (lowCnt_q >= loss_signal_pin - 12'h001) begin
               losQ <= 1'b1;
               lowCnt_q <= 12'h000;
            end else begin
               lowCnt_q <= lowCnt_q + 12'h001;
            end
         end else if (!winOn_q) begin
            // a clear window only opens on a received pulse
            if (rxMark && rxLevelHigh) begin
               winOn_q <= 1'b1;
               winCnt_q <= 8'h01;
               onesCnt_q <= 8'h01;
               zeroRun_q <= 7'h00;
            end
         end else if (!rxLevelHigh || (!rxMark && zeroRun_q + 7'h01 >= losZmax)) begin
            winOn_q <= 1'b0;
         end else begin
            winCnt_q <= winCnt_q + 8'h01;
            onesCnt_q <= onesNext;
            zeroRun_q <= rxMark ? 7'h00 : zeroRun_q + 7'h01;
            if (winCnt_q + 8'h01 >= losM) begin
               winOn_q <= 1'b0;
               // eight times the marks against the window length gives 12.5 percent
               if ({onesNext, 3'h0} >= {3'h0, losM}) begin
                  losQ <= 1'b0;
               end
            end
         end
      end
   end

   // alarm indication detection over back-to-back blocks
   logic [13:0] aisBlk;
   logic [3:0] aisZthr;
   assign aisBlk = ctrl_q.lineRateSelect ? AIS_BLK_T1 : AIS_BLK_E1;
   assign aisZthr = ctrl_q.lineRateSelect ? AIS_ZTHR_T1 : AIS_ZTHR_E1;

   logic [13:0] blkCnt_q;
   logic [3:0] zeroCnt_q;
   logic prevLow_q;
   logic [3:0] zeroNext;
   logic blkLow;
   assign zeroNext = (!rxMark && zeroCnt_q != 4'hF) ? zeroCnt_q + 4'h1 : zeroCnt_q;
   assign blkLow = zeroNext < aisZthr;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         aisQ <= 1'b0;
         blkCnt_q <= 14'h0000;
         zeroCnt_q <= 4'h0;
         prevLow_q <= 1'b0;
      end else if (!ctrl_q.clockDataRecovery) begin
         aisQ <= 1'b0;
         blkCnt_q <= 14'h0000;
         zeroCnt_q <= 4'h0;
         prevLow_q <= 1'b0;
      end else if (rxBitEn) begin
         if (blkCnt_q >= aisBlk - 14'h0001) begin
            blkCnt_q <= 14'h0000;
            zeroCnt_q <= 4'h0;
            prevLow_q <= blkLow;
            if (ctrl_q.lineRateSelect) begin
               aisQ <= blkLow;
            end else if (blkLow && prevLow_q) begin
               aisQ <= 1'b1;
            end else if (!blkLow && (!prevLow_q || ctrl_q.criterionSelect)) begin
               aisQ <= 1'b0;
            end
         end else begin
            blkCnt_q <= blkCnt_q + 14'h0001;
            zeroCnt_q <= zeroNext;
         end
      end
   end

   // system receive output
   logic rxSubst;
   assign rxSubst = losQ & ctrl_q.rxAlarmSubstituteEn;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rxDataPosNeg <= 2'h0;
         rxClkOut <= 1'b0;
      end else if (rxSubst) begin
         rxClkOut <= mclkEn_q;
         if (mclkEn_q) begin
            rxDataPosNeg <= RX_MARK;
         end
      end else begin
         rxClkOut <= rxBitEn;
         if (rxBitEn) begin
            rxDataPosNeg <= {rxDataNeg, rxDataPos};
         end
      end
   end

   // transmit pattern selection
   logic txAis;
   logic txTick;
   logic txBit;
   logic txPattern;
   assign txAis = losQ & ctrl_q.txAlarmOnLossEn;

   always_comb begin
      txPattern = 1'b0;
      if (txAis) begin
         txTick = mclkEn_q;
         txBit = 1'b1;
      end else begin
         txTick = ctrl_q.patternClkSelect ? mclkEn_q : txClkIn;
         unique case (ctrl_q.txPatternSelect)
            PATT_NORMAL: txBit = ctrl_q.patternClkSelect ? 1'b0 : txSysData;
            PATT_ONES: txBit = 1'b1;
            PATT_PRBS: begin
               txBit = prbsBit;
               txPattern = 1'b1;
            end
            PATT_LOOP: begin
               txBit = loopCodeBit;
               txPattern = 1'b1;
            end
         endcase
      end
   end

   // marks alternate polarity on the line pair
   logic markPol_q;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         txLinePair <= 2'h0;
         txClkOut <= 1'b0;
         patternAdvance <= 1'b0;
         markPol_q <= 1'b0;
      end else begin
         txClkOut <= txTick;
         patternAdvance <= txTick & txPattern;
         if (txTick) begin
            if (txBit) begin
               txLinePair <= markPol_q ? TX_MARK_NEG : TX_MARK_POS;
               markPol_q <= ~markPol_q;
            end else begin
               txLinePair <= 2'h0;
            end
         end
      end
   end

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   sequence s_lowRun;
      rxBitEn && rxLevelLow && !losQ && lowCnt_q == loss_signal_pin - 12'h001;
   endsequence

   a_los_declare_count: assert property (s_lowRun |=> losQ)
      else $error("loss not declared at final low interval");
   a_los_pin_follow: assert property (1'b1 |=> lossSignalPin == $past(losQ))
      else $error("loss pin does not follow loss state");
   a_los_in_loopback: assert property ((!rxBitEn && $changed(ctrl_q.loopbackMode)) |=> $stable(losQ))
      else $error("loopback change moved loss state");
   a_rx_ones_out: assert property ((rxSubst && mclkEn_q) |=> rxDataPosNeg == RX_MARK && rxClkOut)
      else $error("receive all ones missing during substitution");
   a_rx_clock_swap: assert property ((rxSubst && rxBitEn && !mclkEn_q) |=> !rxClkOut)
      else $error("recovered clock leaked during substitution");
   a_rx_pass_data: assert property ((losQ && !rxSubst && rxBitEn) |=>
      rxClkOut && rxDataPosNeg == $past({rxDataNeg, rxDataPos}))
      else $error("received pulses not passed through");
   a_tx_alarm_ones: assert property ((txAis && mclkEn_q) |=> txClkOut && txLinePair != 2'h0)
      else $error("transmit alarm ones not sent");
   a_tx_zero_patt: assert property ((!txAis && ctrl_q.patternClkSelect && ctrl_q.txPatternSelect == PATT_NORMAL
      && mclkEn_q) |=> txLinePair == 2'h0)
      else $error("all zeros pattern not sent");
   a_tx_normal_data: assert property ((!txAis && !ctrl_q.patternClkSelect && ctrl_q.txPatternSelect == PATT_NORMAL
      && txClkIn) |=> (txLinePair != 2'h0) == $past(txSysData))
      else $error("normal transmit data altered");
   a_ais_needs_cdr: assert property (!ctrl_q.clockDataRecovery |=> !aisQ && blkCnt_q == 14'h0000)
      else $error("alarm detection active without clock recovery");

endmodule

// file: verification/lal_line_model.sv
module lal_line_model (
   // clock
   input wire logic core_clk,
   // receive line toward the block
   output logic rxBitEn,
   output logic rxDataPos,
   output logic rxDataNeg,
   output logic rxLevelLow,
   output logic rxLevelHigh
);
   timeunit 1ns;
   timeprecision 1ns;
   logic pol = 1'b0;

   initial begin
      rxBitEn = 1'b0;
      rxDataPos = 1'b0;
      rxDataNeg = 1'b0;
      rxLevelLow = 1'b0;
      rxLevelHigh = 1'b0;
   end

   // one interval every other cycle; marks alternate rails as the line code asks
   task automatic send(input int n, input bit mk, input bit lo, input bit hi);
      for (int i = 0; i < n; i++) begin
         @(posedge core_clk);
         rxBitEn <= 1'b1;
         rxDataPos <= mk & ~pol;
         rxDataNeg <= mk & pol;
         rxLevelLow <= lo;
         rxLevelHigh <= hi;
         if (mk)
            pol <= ~pol;
         @(posedge core_clk);
         rxBitEn <= 1'b0;
         // rails mean nothing between intervals, so keep them moving
         rxDataPos <= ~rxDataPos;
         rxDataNeg <= ~rxDataNeg;
      end
   endtask
endmodule

// file: verification/testbench.sv
module testbench import lal_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic reset_n, regWrEn, regRdEn, txClkIn, txSysData, prbsBit, loopCodeBit;
   logic [3:0] regAddr;
   logic [15:0] regWrData, regRdData;
   logic rxBitEn, rxDataPos, rxDataNeg, rxLevelLow, rxLevelHigh, rxClkOut, txClkOut, lossSignalPin;
   logic [1:0] rxDataPosNeg, txLinePair;
   logic signed [7:0] lossDeclareDb, lossClearDb;
   int num_errors = 0;
   int check_count = 0;
   logic [15:0] regQ[$];
   logic [1:0] rxQ[$];
   logic [2:0] txQ[$];
   logic patAdv;
   logic [31:0] seed = 32'h00007C89;
   bit txPol = 1'b0;
   logic rdPend = 1'b0;
   lal_ctrl_t ctl;

   lal_alarm dut (.core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .rxBitEn(rxBitEn),
      .rxDataPos(rxDataPos), .rxDataNeg(rxDataNeg), .rxLevelLow(rxLevelLow), .rxLevelHigh(rxLevelHigh),
      .rxDataPosNeg(rxDataPosNeg), .rxClkOut(rxClkOut), .txClkIn(txClkIn), .txSysData(txSysData),
      .prbsBit(prbsBit), .loopCodeBit(loopCodeBit), .patternAdvance(patAdv), .txLinePair(txLinePair),
      .txClkOut(txClkOut), .lossSignalPin(lossSignalPin), .lossDeclareDb(lossDeclareDb),
      .lossClearDb(lossClearDb));

   lal_line_model line (.core_clk(core_clk), .rxBitEn(rxBitEn), .rxDataPos(rxDataPos),
      .rxDataNeg(rxDataNeg), .rxLevelLow(rxLevelLow), .rxLevelHigh(rxLevelHigh));

   initial forever #10 core_clk = ~core_clk;

   task automatic chk(input bit ok, input string msg);
      check_count++;
      if (!ok) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask

   task automatic end_sim;
      $display("errors %0d, checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   function automatic logic signed [7:0] dbOf(input logic [4:0] c);
      if (c > THR_LAST_CODE)
         return THR_FLOOR_DB;
      return 8'(int'(THR_TOP_DB) - 2 * int'(c));
   endfunction

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      regWrEn <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge core_clk);
      regWrEn <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge core_clk);
      regRdEn <= 1'b1;
      regAddr <= a;
      regQ.push_back(e);
      @(posedge core_clk);
      regRdEn <= 1'b0;
   endtask

   task automatic wrCtl;
      wr(REG_CTRL, {5'h00, ctl});
   endtask

   task automatic pushTx(input bit b);
      txQ.push_back({ctl.txPatternSelect[1], (b ? (txPol ? 2'h2 : 2'h1) : 2'h0)});
      if (b)
         txPol = ~txPol;
   endtask

   task automatic sendTx;
      logic [31:0] r;
      r = seed ^ (seed << 13);
      r = r ^ (r >> 17);
      r = r ^ (r << 5);
      seed = r;
      case (ctl.txPatternSelect)
         PATT_NORMAL: pushTx(r[0]);
         PATT_ONES: pushTx(1'b1);
         PATT_PRBS: pushTx(r[1]);
         default: pushTx(r[2]);
      endcase
      @(posedge core_clk);
      txClkIn <= 1'b1;
      txSysData <= r[0];
      prbsBit <= r[1];
      loopCodeBit <= r[2];
      @(posedge core_clk);
      txClkIn <= 1'b0;
   endtask

   always @(posedge core_clk) begin
      if (rdPend) begin
         if (regQ.size() == 0)
            chk(1'b0, "read data without a note");
         else
            chk(regRdData === regQ.pop_front(), "read data");
      end
      rdPend <= regRdEn;
      if (txClkOut === 1'b1 && txQ.size() > 0)
         chk({patAdv, txLinePair} === txQ.pop_front(), "line output");
      if (rxClkOut === 1'b1 && rxQ.size() > 0)
         chk(rxDataPosNeg === rxQ.pop_front(), "system receive data");
   end

   initial begin
      #1_000_000;
      num_errors++;
      $display("CHECK FAILED at %0t: watchdog ran out", $time);
      end_sim();
   end

   initial begin
      reset_n = 1'b0;
      regAddr = 4'h0;
      regWrData = 16'h0000;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      txClkIn = 1'b0;
      txSysData = 1'b0;
      prbsBit = 1'b0;
      loopCodeBit = 1'b0;
      ctl = lal_ctrl_t'(CTRL_RESET);
      repeat (20) @(posedge core_clk);
      chk(lossDeclareDb === THR_FLOOR_DB, "threshold held in reset");
      reset_n <= 1'b1;
      rd(REG_CTRL, {5'h00, CTRL_RESET});
      rd(REG_THRESH, {11'h000, THRESH_RESET});
      rd(REG_STATUS, 16'h0000);
      wr(4'hF, 16'hFFFF);
      rd(4'hF, 16'h0000);
      rd(REG_CTRL, {5'h00, CTRL_RESET});
      // codes kept inside the mapped range, at or below THR_LAST_CODE, run at the E1 line rate left from reset
      for (int k = 0; k < 3; k++) begin
         logic [4:0] code;
         code = (k == 0) ? 5'h03 : ((k == 1) ? 5'h09 : 5'h0F);
         wr(REG_THRESH, {11'h000, code});
         repeat (2) @(posedge core_clk);
         chk(lossDeclareDb === dbOf(code), "declare level");
         chk(lossClearDb === 8'(dbOf(code) + THR_HYST_DB), "clear level");
      end
      for (int p = 0; p < 4; p++) begin
         ctl.txPatternSelect = 2'(p);
         wrCtl();
         repeat (4) sendTx();
      end
      ctl.txPatternSelect = PATT_NORMAL;
      ctl.patternClkSelect = 1'b1;
      pushTx(1'b0);
      pushTx(1'b0);
      wrCtl();
      repeat (80) @(posedge core_clk);
      chk(txQ.size() == 0, "master clock zeros");
      ctl.patternClkSelect = 1'b0;
      wrCtl();
      line.send(31, 1'b0, 1'b1, 1'b0);
      repeat (4) @(posedge core_clk);
      chk(lossSignalPin === 1'b0, "loss one interval early");
      ctl.loopbackMode = 3'h7;
      wrCtl();
      line.send(1, 1'b0, 1'b1, 1'b0);
      repeat (4) @(posedge core_clk);
      chk(lossSignalPin === 1'b1, "loss declared");
      rd(REG_STATUS, 16'h0001);
      repeat (2) begin
         rxQ.push_back(line.pol ? 2'h2 : 2'h1);
         line.send(1, 1'b1, 1'b1, 1'b0);
      end
      ctl.rxAlarmSubstituteEn = 1'b1;
      rxQ.push_back(2'h1);
      rxQ.push_back(2'h1);
      wrCtl();
      repeat (60) @(posedge core_clk);
      chk(rxQ.size() == 0, "all ones on master clock");
      ctl.txAlarmOnLossEn = 1'b1;
      pushTx(1'b1);
      pushTx(1'b1);
      wrCtl();
      repeat (80) @(posedge core_clk);
      chk(txQ.size() == 0, "line all ones during loss");
      ctl = lal_ctrl_t'(CTRL_RESET);
      wrCtl();
      // a zero run of 16 aborts the window, so the next 15 marks start a fresh one
      line.send(1, 1'b1, 1'b0, 1'b1);
      line.send(16, 1'b0, 1'b0, 1'b1);
      line.send(15, 1'b1, 1'b0, 1'b1);
      repeat (4) @(posedge core_clk);
      chk(lossSignalPin === 1'b1, "zero run must abort clearing");
      line.send(17, 1'b1, 1'b0, 1'b1);
      repeat (4) @(posedge core_clk);
      chk(lossSignalPin === 1'b0, "loss cleared");
      line.send(1536, 1'b1, 1'b0, 1'b1);
      repeat (4) @(posedge core_clk);
      rd(REG_STATUS, 16'h0002);
      ctl.clockDataRecovery = 1'b0;
      wrCtl();
      repeat (4) @(posedge core_clk);
      rd(REG_STATUS, 16'h0000);
      ctl.clockDataRecovery = 1'b1;
      ctl.criterionSelect = 1'b1;
      wrCtl();
      line.send(1100, 1'b1, 1'b0, 1'b1);
      repeat (4) @(posedge core_clk);
      rd(REG_STATUS, 16'h0002);
      repeat (160) begin
         line.send(3, 1'b1, 1'b0, 1'b1);
         line.send(1, 1'b0, 1'b0, 1'b1);
      end
      repeat (4) @(posedge core_clk);
      rd(REG_STATUS, 16'h0000);
      repeat (4) @(posedge core_clk);
      chk(regQ.size() == 0, "reads left unanswered");
      end_sim();
   end
endmodule
